//--- ssso_sync_serial_send.sv
// Purpose: shifts queued values out on a data pin with a low-idle serial clock
// Assumes: clk_link runs free; the peripheral takes one bit per clock pulse
// Notes: words cross from clk_sys to clk_link by a toggle handshake
// Contract
// R1: clock low, data pin output before bits
// R2: set data bit, then one clock pulse
// R3: order 0 lowest bit first, 1 highest
// R4: default eight bits, 1 to 16 pulses
// R5: short counts send only the lowest bits
// R6: values of one frame sent back to back
// R7: values and counts sampled when transfer starts
// R8: peripheral captures one bit per rising clock edge
// R9: high and low times are parameters, clock ends low
`timescale 1ns/1ps
module ssso_sync_serial_send #(
    parameter int HIGH_CYC = ssso_pkg::SCLK_HIGH_CYC,
    parameter int LOW_CYC = ssso_pkg::SCLK_LOW_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic send_valid,
    output logic send_ready,
    input wire logic [15:0] send_value,
    input wire logic [4:0] send_bits,
    input wire logic send_order,
    input wire logic send_last,
    output logic busy,
    output logic frame_done,
    input wire logic clk_link,
    output logic sclk_o,
    output logic sclk_oe,
    output logic sdata_o,
    output logic sdata_oe
);
    localparam int VW = ssso_pkg::VAL_W;
    localparam int BW = ssso_pkg::BITS_W;
    localparam int IW = ssso_pkg::IDX_W;
    localparam int CW = ssso_pkg::CNT_W;
    localparam int WW = ssso_pkg::WORD_W;

    // ---- system clock side ----
    logic [WW-1:0] in_word, q_word;
    logic q_valid, q_ready;
    logic [WW-1:0] hold_q, hold_d;
    logic req_q, req_d, pend_q, pend_d;
    logic ack1_q, ack2_q, ack3_q;
    logic bsy1_q, bsy2_q, bsy3_q, bsy_lvl_q, bsy_lvl_d;
    logic dn1_q, dn2_q, dn3_q, dn_seen_q, dn_seen_d;
    logic busy_q, busy_d, done_q, done_d;
    logic seen_q, seen_d, done_tgl_q, done_tgl_d, lbusy_q; // link registers read by the synchronisers

    // pack one request word; the queue keeps each value with its own count
    assign in_word = {send_last, send_order, send_bits, send_value}; // [R6]

    ssso_fifo #(.W(WW), .DEPTH(ssso_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk_sys), .arst_n(arst_n),
        .in_valid(send_valid), .in_ready(send_ready), .in_data(in_word),
        .out_valid(q_valid), .out_ready(q_ready), .out_data(q_word)
    );

    // one word in flight; the queue stalls while the link owns it
    assign q_ready = !pend_q;

    // handshake: hold word steady and toggle request; clear on matching ack
    always_comb begin
        hold_d = hold_q;
        req_d = req_q;
        pend_d = pend_q;
        if (pend_q) begin
            if ((ack2_q == ack3_q) && (ack3_q == req_q)) begin
                pend_d = 1'b0;
            end
        end else if (q_valid) begin
            hold_d = q_word; // [R7]
            req_d = !req_q;
            pend_d = 1'b1;
        end
    end

    // status back from the link: level for busy, toggle for frame end
    always_comb begin
        bsy_lvl_d = (bsy2_q == bsy3_q) ? bsy3_q : bsy_lvl_q;
        dn_seen_d = dn_seen_q;
        done_d = 1'b0;
        if ((dn2_q == dn3_q) && (dn3_q != dn_seen_q)) begin
            dn_seen_d = dn3_q;
            done_d = 1'b1;
        end
        busy_d = q_valid || pend_q || bsy_lvl_q;
    end

    // first stage of each synchroniser feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= '0;
            req_q <= 1'b0;
            pend_q <= 1'b0;
            ack1_q <= 1'b0;
            ack2_q <= 1'b0;
            ack3_q <= 1'b0;
            bsy1_q <= 1'b0;
            bsy2_q <= 1'b0;
            bsy3_q <= 1'b0;
            bsy_lvl_q <= 1'b0;
            dn1_q <= 1'b0;
            dn2_q <= 1'b0;
            dn3_q <= 1'b0;
            dn_seen_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            req_q <= req_d;
            pend_q <= pend_d;
            ack1_q <= seen_q;
            ack2_q <= ack1_q;
            ack3_q <= ack2_q;
            bsy1_q <= lbusy_q;
            bsy2_q <= bsy1_q;
            bsy3_q <= bsy2_q;
            bsy_lvl_q <= bsy_lvl_d;
            dn1_q <= done_tgl_q;
            dn2_q <= dn1_q;
            dn3_q <= dn2_q;
            dn_seen_q <= dn_seen_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign frame_done = done_q;

    // ---- link clock side ----
    logic lrst1_q, lrst_n_q;
    logic rq1_q, rq2_q, rq3_q;
    ssso_pkg::ssso_link_st_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [VW-1:0] val_q, val_d;
    logic [BW-1:0] nb_q, nb_d;
    logic [IW-1:0] idx_q, idx_d;
    logic ord_q, ord_d, last_q, last_d;
    logic sclk_q, sclk_d, sdata_q, sdata_d, oe_q, oe_d;
    logic new_word, take, last_bit;
    logic [BW-1:0] w_bits, w_nb;
    logic [VW-1:0] w_val;
    logic w_ord;
    logic [IW-1:0] w_first, idx_next;

    // link reset enters asynchronously, releases on the link clock
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            lrst1_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst1_q <= 1'b1;
            lrst_n_q <= lrst1_q;
        end
    end

    // a request counts once second and third stages agree
    assign new_word = (rq2_q == rq3_q) && (rq3_q != seen_q);
    assign take = new_word && ((st_q == ssso_pkg::L_IDLE) || (st_q == ssso_pkg::L_WAIT));

    // decode the held word; zero count means default, above sixteen clamps
    assign w_val = hold_q[ssso_pkg::POS_VAL +: VW];
    assign w_bits = hold_q[ssso_pkg::POS_BITS +: BW];
    assign w_ord = hold_q[ssso_pkg::POS_ORDER];
    always_comb begin
        if (w_bits == ssso_pkg::NO_BITS) begin
            w_nb = ssso_pkg::DEFAULT_BITS; // [R4]
        end else if (w_bits > ssso_pkg::MAX_BITS) begin
            w_nb = ssso_pkg::MAX_BITS;
        end else begin
            w_nb = w_bits;
        end
    end

    // start index: highest wanted bit or bit zero; upper bits never indexed
    assign w_first = (w_ord == ssso_pkg::HIGH_BIT_FIRST) ? IW'(w_nb - 1'b1) : '0; // [R3] [R5]
    assign last_bit = (ord_q == ssso_pkg::HIGH_BIT_FIRST) ? (idx_q == '0)
                                                           : (idx_q == IW'(nb_q - 1'b1));
    assign idx_next = (ord_q == ssso_pkg::HIGH_BIT_FIRST) ? idx_q - 1'b1 : idx_q + 1'b1; // [R3]

    // bit sequencer: data settles during the low phase, then one high pulse
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        val_d = val_q;
        nb_d = nb_q;
        idx_d = idx_q;
        ord_d = ord_q;
        last_d = last_q;
        sclk_d = sclk_q;
        sdata_d = sdata_q;
        oe_d = oe_q;
        seen_d = seen_q;
        done_tgl_d = done_tgl_q;
        if (take) begin
            seen_d = rq3_q;
            val_d = w_val; // [R7]
            nb_d = w_nb;
            ord_d = w_ord;
            last_d = hold_q[ssso_pkg::POS_LAST];
            idx_d = w_first;
        end
        case (st_q)
            ssso_pkg::L_IDLE: begin
                if (take) begin
                    sclk_d = 1'b0; // [R1]
                    oe_d = 1'b1; // [R1]
                    st_d = ssso_pkg::L_START;
                end
            end
            ssso_pkg::L_START: begin
                sdata_d = val_q[idx_q]; // [R2]
                cnt_d = CW'(LOW_CYC - 1);
                st_d = ssso_pkg::L_SETUP;
            end
            ssso_pkg::L_SETUP: begin
                if (cnt_q == '0) begin
                    sclk_d = 1'b1; // [R2]
                    cnt_d = CW'(HIGH_CYC - 1); // [R9]
                    st_d = ssso_pkg::L_HIGH;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ssso_pkg::L_HIGH: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    sclk_d = 1'b0; // [R9]
                    if (!last_bit) begin
                        idx_d = idx_next;
                        sdata_d = val_q[idx_next]; // [R2]
                        cnt_d = CW'(LOW_CYC - 1); // [R9]
                        st_d = ssso_pkg::L_SETUP;
                    end else if (last_q) begin
                        done_tgl_d = !done_tgl_q;
                        st_d = ssso_pkg::L_IDLE;
                    end else begin
                        st_d = ssso_pkg::L_WAIT; // [R6]
                    end
                end
            end
            ssso_pkg::L_WAIT: begin
                if (take) begin
                    sdata_d = w_val[w_first]; // [R6]
                    cnt_d = CW'(LOW_CYC - 1);
                    st_d = ssso_pkg::L_SETUP;
                end
            end
            default: begin
                sclk_d = 1'b0;
                st_d = ssso_pkg::L_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_link or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            rq1_q <= 1'b0;
            rq2_q <= 1'b0;
            rq3_q <= 1'b0;
            seen_q <= 1'b0;
            done_tgl_q <= 1'b0;
            lbusy_q <= 1'b0;
            st_q <= ssso_pkg::L_IDLE;
            cnt_q <= '0;
            val_q <= '0;
            nb_q <= ssso_pkg::DEFAULT_BITS;
            idx_q <= '0;
            ord_q <= ssso_pkg::LOW_BIT_FIRST;
            last_q <= 1'b0;
            sclk_q <= 1'b0;
            sdata_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            rq1_q <= req_q;
            rq2_q <= rq1_q;
            rq3_q <= rq2_q;
            seen_q <= seen_d;
            done_tgl_q <= done_tgl_d;
            lbusy_q <= (st_d != ssso_pkg::L_IDLE);
            st_q <= st_d;
            cnt_q <= cnt_d;
            val_q <= val_d;
            nb_q <= nb_d;
            idx_q <= idx_d;
            ord_q <= ord_d;
            last_q <= last_d;
            sclk_q <= sclk_d;
            sdata_q <= sdata_d;
            oe_q <= oe_d;
        end
    end

    // pins stay driven once the first frame has started
    assign sclk_o = sclk_q;
    assign sclk_oe = oe_q;
    assign sdata_o = sdata_q;
    assign sdata_oe = oe_q;

    // ---- checking helpers: pulses in current value and high length ----
    logic [BW-1:0] pk_q;
    logic [CW-1:0] hi_len_q;
    always_ff @(posedge clk_link or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            pk_q <= '0;
            hi_len_q <= '0;
        end else begin
            if (take) begin
                pk_q <= '0;
            end else if (sclk_q && !sclk_d) begin
                pk_q <= pk_q + 1'b1;
            end
            hi_len_q <= sclk_q ? hi_len_q + 1'b1 : '0;
        end
    end

    // pins must be driven and clock low before any pulse
    a_pins_driven: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R1]
        $rose(sclk_q) |-> sdata_oe && sclk_oe && $past(st_q) == ssso_pkg::L_SETUP)
        else $error("clock pulse without driven pins");
    // data moves only while the clock is low: steady at the rise and through the whole high phase
    a_data_setup: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R2]
        sclk_q |-> $stable(sdata_q))
        else $error("data moved around the clock rise");
    // bit on the pin at each rise matches the selected order
    a_bit_order: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R3]
        $rose(sclk_q) |-> sdata_q == ((ord_q == ssso_pkg::HIGH_BIT_FIRST)
            ? val_q[IW'(nb_q - 1'b1 - pk_q)] : val_q[IW'(pk_q)]))
        else $error("wrong bit for the selected order");
    // exactly the requested number of pulses per value
    a_pulse_count: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R4]
        $fell(sclk_q) && (st_q != ssso_pkg::L_SETUP) |-> pk_q == nb_q)
        else $error("pulse count differs from bit count");
    // a zero count loads the default of eight
    a_default_bits: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R4]
        take && w_bits == ssso_pkg::NO_BITS |=> nb_q == ssso_pkg::DEFAULT_BITS)
        else $error("default bit count not applied");
    // only indices below the count are ever put on the pin
    a_low_bits_only: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R5]
        (st_q == ssso_pkg::L_SETUP || st_q == ssso_pkg::L_HIGH) |-> 5'(idx_q) < nb_q)
        else $error("bit above the count selected");
    // value without end mark waits in frame, clock low, no done toggle
    a_frame_chain: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R6]
        st_q == ssso_pkg::L_HIGH && cnt_q == '0 && last_bit && !last_q
        |=> st_q == ssso_pkg::L_WAIT && !sclk_q && $stable(done_tgl_q))
        else $error("frame broken between values");
    // held word stays still while the link may sample it
    a_word_stable: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R7]
        pend_q && $past(pend_q) |-> $stable(hold_q) && $stable(req_q))
        else $error("held word changed during handshake");
    // high phase lasts exactly the set number of link cycles; the counter holds it at the fall
    a_high_time: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R9]
        $fell(sclk_q) |-> hi_len_q == CW'(HIGH_CYC) && $past(hi_len_q) == CW'(HIGH_CYC - 1))
        else $error("clock high time wrong");
    // clock low in the start cycle and the first setup cycle, whatever the low time is
    a_idle_low: assert property (@(posedge clk_link) disable iff (!lrst_n_q) // [R9]
        st_q == ssso_pkg::L_START |-> !sclk_q [*2])
        else $error("clock not low at frame start");
endmodule // ssso_sync_serial_send

//--- ssso_pkg.sv
// Purpose: shared constants for the synchronous serial shift-out block
// Assumes: one queued word carries value, bit count, bit order and end-of-frame
// Notes: times are in ns; cycle counts are derived from the link clock period
package ssso_pkg;
    // queued word layout
    localparam int VAL_W = 16;
    localparam int BITS_W = 5;
    localparam int IDX_W = 4;
    localparam int WORD_W = 23;
    localparam int POS_VAL = 0;
    localparam int POS_BITS = 16;
    localparam int POS_ORDER = 21;
    localparam int POS_LAST = 22;
    localparam int FIFO_DEPTH = 8;
    // bit count handling; zero requests the default
    localparam logic [4:0] DEFAULT_BITS = 5'h08;
    localparam logic [4:0] MAX_BITS = 5'h10;
    localparam logic [4:0] NO_BITS = 5'h00;
    // bit order codes
    localparam logic LOW_BIT_FIRST = 1'b0;
    localparam logic HIGH_BIT_FIRST = 1'b1;
    // serial clock timing on the link clock
    localparam int CNT_W = 8;
    localparam int LINK_PERIOD_NS = 125;
    localparam int SCLK_HIGH_NS = 500;
    localparam int SCLK_LOW_NS = 500;
    localparam int SCLK_HIGH_CYC = (SCLK_HIGH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int SCLK_LOW_CYC = (SCLK_LOW_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    // link state machine, one-hot
    typedef enum logic [4:0] {
        L_IDLE = 5'h01,
        L_START = 5'h02,
        L_SETUP = 5'h04,
        L_HIGH = 5'h08,
        L_WAIT = 5'h10
    } ssso_link_st_t;
endpackage

//--- ssso_fifo.sv
// Purpose: small first-word-fall-through queue between the user and the link crossing
// Assumes: DEPTH is a power of two
// Notes: read data come straight from the storage flops at the read pointer
`timescale 1ns/1ps
module ssso_fifo #(
    parameter int W = 23,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // honest flags: full refuses writes, empty hides stale data
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and fill level next values
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; empty flag guards its contents
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // ssso_fifo

//--- ssso_periph_model.sv
// Purpose: behavioural shift-register peripheral on the serial clock and data pins
// Assumes: one bit is taken on each rising edge of the serial clock
// Notes: listens only; it never drives a pin, so no released-line handling is needed
`timescale 1ns/1ps
module ssso_periph_model (
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic sdata,
    output logic [31:0] rx_shift,
    output logic rx_bit,
    output logic [15:0] rx_count
);
    // take the data level at each rising clock edge and move the chain along
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_shift <= 32'h0000_0000;
            rx_bit <= 1'b0;
            rx_count <= 16'h0000;
        end else begin
            rx_shift <= {rx_shift[30:0], sdata};
            rx_bit <= sdata;
            rx_count <= rx_count + 16'h0001; // counter written last, bench wakes on it
        end
    end
endmodule // ssso_periph_model

//--- tb_top.sv
// Purpose: self-checking bench for the serial shift-out block
// Assumes: shortest serial clock phases keep the run short
// Notes: the driver notes expected bits and the running pulse total at each frame end; monitors pop and compare
`timescale 1ns/1ps
module tb_top;
    localparam int HC = 1;
    localparam int LC = 1;
    logic clk_sys, clk_link, arst_n;
    logic send_valid, send_ready, send_order, send_last, busy, frame_done;
    logic [15:0] send_value;
    logic [4:0] send_bits;
    logic sclk_o, sclk_oe, sdata_o, sdata_oe;
    logic [31:0] rx_shift;
    logic rx_bit;
    logic [15:0] rx_count;
    logic exp_bits[$];
    int exp_frames[$];
    int n_errors = 0;
    int comparisons = 0;
    int pushed = 0;
    int seen = 0;
    int refused = 0;

    ssso_sync_serial_send #(.HIGH_CYC(HC), .LOW_CYC(LC)) DUT (
        .clk_sys(clk_sys), .arst_n(arst_n), .send_valid(send_valid),
        .send_ready(send_ready), .send_value(send_value), .send_bits(send_bits),
        .send_order(send_order), .send_last(send_last), .busy(busy),
        .frame_done(frame_done), .clk_link(clk_link), .sclk_o(sclk_o),
        .sclk_oe(sclk_oe), .sdata_o(sdata_o), .sdata_oe(sdata_oe)
    );
    ssso_periph_model peer (
        .arst_n(arst_n), .sclk(sclk_o), .sdata(sdata_o),
        .rx_shift(rx_shift), .rx_bit(rx_bit), .rx_count(rx_count)
    );

    // system clock, 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // link clock, 125 ns, offset so its edges never line up with the system clock
    initial begin
        clk_link = 1'b0;
        #37.3;
        forever #62.5 clk_link = ~clk_link;
    end

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // offer one value; called at a rising edge, valid stays up for back-to-back use
    task automatic send(logic [15:0] v, logic [4:0] b, logic o, logic l);
        int n;
        int k;
        n = (b == 5'h00) ? 8 : ((b > 5'h10) ? 16 : int'(b));
        for (int i = 0; i < n; i++) begin
            k = o ? n - 1 - i : i;
            exp_bits.push_back(v[k]);
        end
        pushed += n;
        if (l) exp_frames.push_back(pushed);
        send_valid <= 1'b1;
        send_value <= v;
        send_bits <= b;
        send_order <= o;
        send_last <= l;
        @(negedge clk_sys);
        // ready only moves at rising edges, so the falling edge is a safe look
        while (send_ready !== 1'b1) begin
            refused++;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
    endtask

    // drop valid and scramble value and count: words already taken must not follow them
    task automatic idle();
        send_valid <= 1'b0;
        send_value <= 16'($urandom);
        send_bits <= 5'($urandom);
        @(posedge clk_sys);
    endtask

    task automatic drain();
        repeat (8) @(posedge clk_sys);
        while (busy !== 1'b0) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
    endtask

    // each captured bit against the oldest noted one; pins must be driven by then
    always @(rx_count) begin
        #1;
        if (arst_n === 1'b1 && rx_count !== 16'h0000) begin
            seen++;
            if (exp_bits.size() == 0) begin
                n_errors++;
                $display("CHECK FAILED serial bit expected none seen %b", rx_bit);
            end else begin
                check("serial bit", 16'(exp_bits.pop_front()), 16'(rx_bit));
            end
            check("pin enables", 16'h0003, {14'h0000, sclk_oe, sdata_oe});
        end
    end

    // frame end: pulse count so far must equal the noted total, clock left low
    always @(negedge clk_sys) begin
        if (frame_done === 1'b1) begin
            if (exp_frames.size() == 0) begin
                n_errors++;
                $display("CHECK FAILED frame end expected none seen %0d", seen);
            end else begin
                check("pulses per frame", 16'(exp_frames.pop_front()), 16'(seen));
            end
            check("clock after frame", 16'h0000, {15'h0000, sclk_o});
        end
    end

    // watchdog, sized above the expected run of about 32k cycles
    initial begin
        repeat (95000) @(posedge clk_sys);
        n_errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        // start high and fall after time zero, so every process sees the reset edge
        arst_n = 1'b1;
        send_valid = 1'b0;
        send_value = 16'h0000;
        send_bits = 5'h00;
        send_order = 1'b0;
        send_last = 1'b0;
        void'($urandom(82));
        #1 arst_n = 1'b0;
        // three link edges so both domains see the reset
        repeat (3) @(posedge clk_link);
        check("ready in reset", 16'h0001, {15'h0000, send_ready});
        @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check("idle pins", 16'h0000, {12'h000, sclk_o, sclk_oe, sdata_o, sdata_oe});
        // count codes 0 to 17, default and clamp included, in both orders
        for (int b = 0; b < 18; b++) begin
            for (int o = 0; o < 2; o++) begin
                send(16'($urandom), 5'(b), o[0], 1'b1);
            end
        end
        idle();
        drain();
        // a 4-bit piece then a 16-bit value form one 20-pulse frame
        send(16'h00fa, 5'h04, ssso_pkg::HIGH_BIT_FIRST, 1'b0);
        send(16'h0415, 5'h10, ssso_pkg::HIGH_BIT_FIRST, 1'b1);
        idle();
        drain();
        // the whole 20-bit frame as the peripheral chain holds it
        check("frame low word", 16'h0415, rx_shift[15:0]);
        check("frame high piece", 16'h000a, {12'h000, rx_shift[19:16]});
        // burst beyond the queue depth while the link is slow, mixed orders
        refused = 0;
        for (int i = 0; i < 14; i++) begin
            send(16'($urandom), 5'($urandom_range(1, 16)), i[0], i == 13);
        end
        idle();
        check("queue refused when full", 16'h0001, {15'h0000, refused > 0});
        drain();
        check("busy at end", 16'h0000, {15'h0000, busy});
        check("bits left", 16'h0000, 16'(exp_bits.size()));
        check("frames left", 16'h0000, 16'(exp_frames.size()));
        check("clock idle at end", 16'h0000, {15'h0000, sclk_o});
        end_sim();
    end
endmodule // tb_top
